// [design/rbd_pkg.sv]
// Constants for the 16-kilobyte RAM board bus decode.
// Assumes one 40 MHz system clock; all backplane signals arrive asynchronously.
package rbd_pkg;
   // Bus and storage widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int IDX_W = 14;
   localparam int DEPTH = 16384;
   localparam int SW_W = 2;
   localparam int NBLK = 4;
   localparam int CE_W = 16;
   // Field positions in the latched high address byte
   localparam int WORD_LSB = 0;
   localparam int CHIP_LSB = 2;
   localparam int BLK_LSB = 4;
   localparam int MATCH_LSB = 6;
   localparam int IN_BLK_W = 6;
   // Control synchroniser packing: {strobe, rd_n, wr_n, inhibit, switch[1:0]}
   localparam int CTL_W = 6;
   localparam int CTL_TPA = 5;
   localparam int CTL_RD = 4;
   localparam int CTL_WR = 3;
   localparam int CTL_RNU = 2;
   localparam int CTL_SW = 0;
   // Reset values: read/write strobes idle high (inactive), address strobe low, latch cleared
   localparam logic [CTL_W-1:0] CTL_RST = 6'h18;
   localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   localparam logic [1:0] RST_SYNC_RST = 2'h0;
endpackage

// [design/rbd_top.sv]
// Bus interface, address decode and byte storage of a 16-kilobyte RAM board.
// Assumes a multiplexed 8-bit address bus and asynchronous strobes from the backplane,
// and a 40 MHz clk_sys_i much faster than the strobes.
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; output follows only when stages two and three agree
module rbd_sync3 #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Asynchronous input and filtered result
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] q_d;

   // Per bit: a change counts once the two later stages agree
   assign q_d = (s2_q & s3_q) | (q_o & (s2_q | s3_q));

   // Stage one is read by stage two only
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1_q <= RST;
         s2_q <= RST;
         s3_q <= RST;
         q_o <= RST;
      end else begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         q_o <= q_d;
      end
   end
endmodule

module rbd_top #(
   parameter bit RNU_LINK = 1'b1, // Build option: inhibit path fitted
   parameter logic [3:0] BLK_FIT = 4'hf // Build option: one bit per 4-kilobyte block
) (
   // Clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   // Backplane address and strobes
   input wire logic address_latch_strobe_i,
   input wire logic [rbd_pkg::ADDR_W-1:0] shared_address_lines_i,
   input wire logic memory_read_strobe_n_i,
   input wire logic memory_write_strobe_n_i,
   input wire logic run_utility_inhibit_i,
   // Block select switch, bit 0 is position 1, closed = 1
   input wire logic [rbd_pkg::SW_W-1:0] block_select_switch_i,
   // Bidirectional data lines
   input wire logic [rbd_pkg::DATA_W-1:0] bidir_data_lines_i,
   output logic [rbd_pkg::DATA_W-1:0] bidir_data_lines_o,
   output logic bidir_data_lines_oe_n_o,
   // Decode status
   output logic board_enable_o,
   output logic [rbd_pkg::CE_W-1:0] chip_enable_o,
   output logic [1:0] mem_word_addr_o
);
   logic [1:0] rst_sync_q;
   logic rst_n;
   logic [rbd_pkg::CTL_W-1:0] ctl_raw;
   logic [rbd_pkg::CTL_W-1:0] ctl_f;
   logic [rbd_pkg::ADDR_W-1:0] addr_f;
   logic [rbd_pkg::DATA_W-1:0] data_f;
   logic tpa_f;
   logic rd_n_f;
   logic wr_n_f;
   logic rnu_f;
   logic [rbd_pkg::SW_W-1:0] sw_f;
   logic tpa_prev_q;
   logic wr_prev_q;
   logic strobe_fall;
   logic wr_end;
   logic [rbd_pkg::ADDR_W-1:0] hi_q;
   logic [rbd_pkg::ADDR_W-1:0] wr_lo_q;
   logic [rbd_pkg::DATA_W-1:0] wr_data_q;
   logic wr_en_q;
   logic [rbd_pkg::DATA_W-1:0] rd_data_q;
   logic [rbd_pkg::DATA_W-1:0] mem_q [0:rbd_pkg::DEPTH-1];
   logic [1:0] blk_sel;
   logic [1:0] chip_sel;
   logic [rbd_pkg::SW_W-1:0] hi_match;
   logic sw_match;
   logic inhibit;
   logic board_en;
   logic access;
   logic [rbd_pkg::IDX_W-1:0] rd_idx;
   logic [rbd_pkg::IDX_W-1:0] wr_idx;

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_sync_q <= rbd_pkg::RST_SYNC_RST;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // Backplane pins are asynchronous; strobes are slow so 4 cycles of latency is harmless
   assign ctl_raw = {address_latch_strobe_i, memory_read_strobe_n_i,
                     memory_write_strobe_n_i, run_utility_inhibit_i, block_select_switch_i};

   rbd_sync3 #(.W(rbd_pkg::CTL_W), .RST(rbd_pkg::CTL_RST)) u_sync_ctl (
      .clk_i(clk_sys_i),
      .rst_n_i(rst_n),
      .d_i(ctl_raw),
      .q_o(ctl_f)
   );

   rbd_sync3 #(.W(rbd_pkg::ADDR_W), .RST(rbd_pkg::ADDR_RST)) u_sync_addr (
      .clk_i(clk_sys_i),
      .rst_n_i(rst_n),
      .d_i(shared_address_lines_i),
      .q_o(addr_f)
   );

   rbd_sync3 #(.W(rbd_pkg::DATA_W), .RST(rbd_pkg::DATA_RST)) u_sync_data (
      .clk_i(clk_sys_i),
      .rst_n_i(rst_n),
      .d_i(bidir_data_lines_i),
      .q_o(data_f)
   );

   // Unpack the filtered control group
   assign tpa_f = ctl_f[rbd_pkg::CTL_TPA];
   assign rd_n_f = ctl_f[rbd_pkg::CTL_RD];
   assign wr_n_f = ctl_f[rbd_pkg::CTL_WR];
   assign rnu_f = ctl_f[rbd_pkg::CTL_RNU];
   assign sw_f = ctl_f[rbd_pkg::CTL_SW +: rbd_pkg::SW_W];

   // Edge detection on filtered strobes
   assign strobe_fall = tpa_prev_q & ~tpa_f;
   assign wr_end = ~wr_prev_q & wr_n_f;

   // Address and write data pipeline
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         tpa_prev_q <= 1'b0;
         wr_prev_q <= 1'b1;
         hi_q <= rbd_pkg::ADDR_RST;
         wr_lo_q <= rbd_pkg::ADDR_RST;
         wr_data_q <= rbd_pkg::DATA_RST;
         wr_en_q <= 1'b0;
      end else begin
         tpa_prev_q <= tpa_f;
         wr_prev_q <= wr_n_f;
         if (strobe_fall) begin
            hi_q <= addr_f;
         end
         // Sample through the pulse so the last settled value is written
         if (!wr_n_f) begin
            wr_lo_q <= addr_f;
            wr_data_q <= data_f;
            wr_en_q <= board_en;
         end else if (wr_end) begin
            wr_en_q <= 1'b0;
         end
      end
   end

   // Field decode of the latched high byte
   assign mem_word_addr_o = hi_q[rbd_pkg::WORD_LSB +: 2];
   assign chip_sel = hi_q[rbd_pkg::CHIP_LSB +: 2];
   assign blk_sel = hi_q[rbd_pkg::BLK_LSB +: 2];
   assign hi_match = hi_q[rbd_pkg::MATCH_LSB +: rbd_pkg::SW_W];

   // Board enable: switch match, inhibit option and block fit option together
   assign sw_match = (hi_match == sw_f);
   assign inhibit = RNU_LINK & rnu_f;
   assign board_en = sw_match & ~inhibit & BLK_FIT[blk_sel];
   assign board_enable_o = board_en;

   // Chip enables only during a strobe so idle memories never drive
   assign access = ~rd_n_f | ~wr_n_f;

   genvar g;
   generate
      for (g = 0; g < rbd_pkg::CE_W; g++) begin : g_ce
         localparam logic [3:0] CE_IDX = 4'(g);
         // Group g/4 is the block, g%4 the chip pair within it
         assign chip_enable_o[g] = board_en & access & (blk_sel == CE_IDX[3:2])
                                   & (chip_sel == CE_IDX[1:0]);
      end
   endgenerate

   // Byte index within the 16-kilobyte window
   assign rd_idx = {hi_q[rbd_pkg::IN_BLK_W-1:0], addr_f};
   assign wr_idx = {hi_q[rbd_pkg::IN_BLK_W-1:0], wr_lo_q};

   // Storage; contents are not reset, like the static RAM it models
   always_ff @(posedge clk_sys_i) begin
      if (wr_end && wr_en_q) begin
         mem_q[wr_idx] <= wr_data_q;
      end
   end

   // Read data register feeding the data lines
   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_q <= rbd_pkg::DATA_RST;
      end else begin
         rd_data_q <= mem_q[rd_idx];
      end
   end

   // Drive the backplane only on an enabled read
   assign bidir_data_lines_o = rd_data_q;
   assign bidir_data_lines_oe_n_o = ~(board_en & ~rd_n_f);

   // Latched byte only changes at a strobe trailing edge
   latch_hold_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      !strobe_fall |=> $stable(hi_q))
      else $error("high address changed without strobe");

   latch_capture_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      strobe_fall |=> (hi_q == $past(addr_f)))
      else $error("high address not captured at strobe edge");

   word_bits_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      strobe_fall |=> (mem_word_addr_o == $past(addr_f[1:0])))
      else $error("word address bits wrong");

   one_block_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      $onehot0(chip_enable_o))
      else $error("more than one chip enable active");

   chip_decode_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (board_en && access) |-> chip_enable_o[{blk_sel, chip_sel}])
      else $error("decoded chip enable missing");

   switch_match_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (hi_q[7:6] != sw_f) |-> (!board_enable_o && chip_enable_o == 16'h0000))
      else $error("board enabled on address mismatch");

   buf_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      !board_en |-> bidir_data_lines_oe_n_o)
      else $error("data buffers active without match");

   read_dir_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (board_en && !rd_n_f) |-> !bidir_data_lines_oe_n_o)
      else $error("enabled read not driving data");

   strobe_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (rd_n_f && wr_n_f) |-> (chip_enable_o == 16'h0000 && bidir_data_lines_oe_n_o))
      else $error("chips enabled with no strobe");

   inhibit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (RNU_LINK && rnu_f) |-> !board_enable_o)
      else $error("board enabled under run-utility inhibit");

   hole_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      !BLK_FIT[blk_sel] |-> !board_enable_o)
      else $error("removed block answered");

   inhibit_off_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (!RNU_LINK && hi_q[rbd_pkg::MATCH_LSB +: rbd_pkg::SW_W] == sw_f && BLK_FIT[blk_sel]) |-> board_enable_o)
      else $error("unlinked inhibit blocked the board");

   write_gate_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (!wr_n_f && !board_en) |=> !wr_en_q)
      else $error("write armed while board disabled");

   region_match_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      board_enable_o |-> (hi_q[rbd_pkg::MATCH_LSB +: rbd_pkg::SW_W] == sw_f))
      else $error("board enabled outside its region");

   read_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (board_en && rd_n_f) |-> bidir_data_lines_oe_n_o)
      else $error("data lines driven outside a read");

   store_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n)
      (wr_end && wr_en_q) |=> (mem_q[$past(wr_idx)] == $past(wr_data_q)))
      else $error("write not stored");
endmodule

`default_nettype wire

// [verification/rbd_cpu_model.sv]
// Bus master model: multiplexed address bus, latch strobe, read and write strobes.
// Assumes the bench calls its tasks one at a time; the data wire is resolved here.
`timescale 1ns/1ps
`default_nettype none
module rbd_cpu_model (
   // Clock
   input wire logic clk_i,
   // Address and strobes toward the board
   output logic strobe_o,
   output logic [7:0] addr_o,
   output logic rd_n_o,
   output logic wr_n_o,
   // Data wire and board outputs observed
   input wire logic [7:0] dev_data_i,
   input wire logic dev_oe_n_i,
   input wire logic dev_en_i,
   input wire logic [15:0] dev_ce_i,
   input wire logic [1:0] dev_wa_i,
   output logic [7:0] bus_o
);
   logic [7:0] wdata;
   logic wdrive;
   logic [7:0] idle_q;
   initial begin
      strobe_o = 1'b0; addr_o = 8'h00; rd_n_o = 1'b1; wr_n_o = 1'b1;
      wdata = 8'h00; wdrive = 1'b0; idle_q = 8'h00;
   end
   // Released bus flips every cycle so a stale byte never reads as valid
   always @(posedge clk_i) idle_q <= (dev_oe_n_i === 1'b0) ? ~dev_data_i : ~(wdrive ? wdata : idle_q);
   assign bus_o = (dev_oe_n_i === 1'b0) ? dev_data_i : (wdrive ? wdata : idle_q);
   // High byte under a strobe pulse, then low byte after its fall
   task automatic addr_phase(input logic [15:0] a);
      @(negedge clk_i);
      strobe_o = 1'b1;
      addr_o = a[15:8];
      repeat (6) @(negedge clk_i);
      strobe_o = 1'b0;
      repeat (6) @(negedge clk_i);
      addr_o = a[7:0];
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic oe_n, output logic [15:0] ce);
      addr_phase(a);
      wdata = d;
      wdrive = 1'b1;
      wr_n_o = 1'b0;
      repeat (8) @(negedge clk_i);
      oe_n = dev_oe_n_i;
      ce = dev_ce_i;
      wr_n_o = 1'b1;
      // Data held past the rising edge until the filtered strobe has seen it
      repeat (6) @(negedge clk_i);
      wdrive = 1'b0;
      repeat (4) @(negedge clk_i);
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic oe_n, output logic en,
                     output logic [15:0] ce, output logic [1:0] wa);
      addr_phase(a);
      rd_n_o = 1'b0;
      repeat (8) @(negedge clk_i);
      d = bus_o;
      oe_n = dev_oe_n_i;
      en = dev_en_i;
      ce = dev_ce_i;
      wa = dev_wa_i;
      rd_n_o = 1'b1;
      repeat (8) @(negedge clk_i);
   endtask
endmodule
`default_nettype wire

// [verification/rbd_top_tb.sv]
// Self-checking bench for the RAM board decode, stimulus from the bus master model.
// Assumes default build options on dut; a second build lacks the inhibit path and block 2.
`timescale 1ns/1ps
`default_nettype none
module rbd_top_tb;
   localparam logic [3:0] OPT_FIT = 4'hb;
   logic clk_sys_i, nrst_i, inhibit, ale, rd_n, wr_n, oe_n, en, en_opt;
   logic [1:0] sw, wa;
   logic [7:0] addr, bus, dout;
   logic [15:0] ce;
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   rbd_top dut (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .address_latch_strobe_i(ale),
      .shared_address_lines_i(addr), .memory_read_strobe_n_i(rd_n), .memory_write_strobe_n_i(wr_n),
      .run_utility_inhibit_i(inhibit), .block_select_switch_i(sw), .bidir_data_lines_i(bus),
      .bidir_data_lines_o(dout), .bidir_data_lines_oe_n_o(oe_n), .board_enable_o(en),
      .chip_enable_o(ce), .mem_word_addr_o(wa));
   rbd_cpu_model cpu (.clk_i(clk_sys_i), .strobe_o(ale), .addr_o(addr), .rd_n_o(rd_n), .wr_n_o(wr_n),
      .dev_data_i(dout), .dev_oe_n_i(oe_n), .dev_en_i(en), .dev_ce_i(ce), .dev_wa_i(wa), .bus_o(bus));
   // Second build on the same bus; only its enable is watched, it never drives the data lines
   rbd_top #(.RNU_LINK(1'b0), .BLK_FIT(OPT_FIT)) dut_opt (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
      .address_latch_strobe_i(ale), .shared_address_lines_i(addr), .memory_read_strobe_n_i(rd_n),
      .memory_write_strobe_n_i(wr_n), .run_utility_inhibit_i(inhibit), .block_select_switch_i(sw),
      .bidir_data_lines_i(bus), .bidir_data_lines_o(), .bidir_data_lines_oe_n_o(), .board_enable_o(en_opt),
      .chip_enable_o(), .mem_word_addr_o());
   // 40 MHz clock
   initial begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   // Hang guard: the full sequence needs well under 3000 cycles
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 6000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // One block per corner of the 16-kilobyte window, written then read back
   task automatic t_store_map();
      logic [15:0] al [4] = '{16'h8000, 16'h9504, 16'ha9fe, 16'hbf3c};
      logic [7:0] d;
      logic o, e;
      logic [15:0] c;
      logic [1:0] w;
      sw = 2'h2;
      repeat (8) @(negedge clk_sys_i);
      for (int i = 0; i < 4; i++) begin
         cpu.wr(al[i], al[i][7:0] ^ 8'h5a, o, c);
         chk("write oe_n", 16'h0001, {15'h0000, o});
         chk("write ce", 16'h0001 << al[i][13:10], c);
      end
      for (int i = 0; i < 4; i++) begin
         cpu.rd(al[i], d, o, e, c, w);
         chk("read data", {8'h00, al[i][7:0] ^ 8'h5a}, {8'h00, d});
         chk("read oe_n", 16'h0000, {15'h0000, o});
         chk("read enable", 16'h0001, {15'h0000, e});
         chk("read ce", 16'h0001 << al[i][13:10], c);
         chk("word addr", {14'h0000, al[i][9:8]}, {14'h0000, w});
         chk("fit enable", {15'h0000, OPT_FIT[al[i][13:12]]}, {15'h0000, en_opt});
      end
   endtask
   // Every switch setting: own region answers, a foreign one is ignored
   task automatic t_switch();
      logic [7:0] d;
      logic o, e;
      logic [15:0] c;
      logic [1:0] w;
      for (int s = 0; s < 4; s++) begin
         sw = s[1:0];
         repeat (8) @(negedge clk_sys_i);
         cpu.wr({s[1:0], 14'h0155}, 8'h30 + s[7:0], o, c);
         cpu.wr({s[1:0] ^ 2'h1, 14'h0155}, 8'hee, o, c);
         chk("foreign write ce", 16'h0000, c);
         cpu.rd({s[1:0] ^ 2'h2, 14'h0155}, d, o, e, c, w);
         chk("foreign oe_n", 16'h0001, {15'h0000, o});
         chk("foreign ce", 16'h0000, c);
         chk("foreign enable", 16'h0000, {15'h0000, e});
         cpu.rd({s[1:0], 14'h0155}, d, o, e, c, w);
         chk("own data", {8'h00, 8'h30 + s[7:0]}, {8'h00, d});
      end
   endtask
   // Run-utility inhibit blocks reads and writes at a matching address
   task automatic t_inhibit();
      logic [7:0] d;
      logic o, e;
      logic [15:0] c;
      logic [1:0] w;
      sw = 2'h0;
      repeat (8) @(negedge clk_sys_i);
      cpu.wr(16'h0200, 8'h11, o, c);
      inhibit = 1'b1;
      repeat (8) @(negedge clk_sys_i);
      cpu.rd(16'h0200, d, o, e, c, w);
      chk("inhibit oe_n", 16'h0001, {15'h0000, o});
      chk("inhibit enable", 16'h0000, {15'h0000, e});
      chk("inhibit ce", 16'h0000, c);
      chk("unlinked enable", {15'h0000, OPT_FIT[0]}, {15'h0000, en_opt});
      cpu.wr(16'h0200, 8'h22, o, c);
      inhibit = 1'b0;
      repeat (8) @(negedge clk_sys_i);
      cpu.rd(16'h0200, d, o, e, c, w);
      chk("after inhibit", 16'h0011, {8'h00, d});
   endtask
   // Main sequence
   initial begin
      nrst_i = 1'b0;
      inhibit = 1'b0;
      sw = 2'h0;
      repeat (3) @(negedge clk_sys_i);
      nrst_i = 1'b1;
      repeat (8) @(negedge clk_sys_i);
      t_store_map();
      t_switch();
      t_inhibit();
      tally_and_finish();
   end
endmodule
`default_nettype wire
